// ===== hdl/tcs_regs.svh
// Constants for the three-channel timer counter core and its controller.
// Assumes inclusion by bare name from the design and checker files.
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
// ----------------------------------------
// Device word addresses (16-bit bus)
// ----------------------------------------
`define TCS_A_CNT   5'h00
`define TCS_A_GR    5'h03
`define TCS_A_GRL   5'h0A
`define TCS_A_RUN   5'h0B
`define TCS_A_SYNC  5'h0C
`define TCS_A_TCS   5'h0D
`define TCS_A_PIO   5'h10
`define TCS_A_STAT  5'h13
`define TCS_A_BUF   5'h14
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TCS_PIO_CAPA 0
`define TCS_PIO_CAPB 1
`define TCS_PIO_INIT 2
`define TCS_CNT_RST  16'h0000
`define TCS_GR_RST   16'hFFFF
`define TCS_CH_MASK  16'h0007
`define TCS_DIV_DEF  4
// ----------------------------------------
// Controller AXI4-Lite byte offsets
// ----------------------------------------
`define TCS_X_CMD    4'h0
`define TCS_X_WDATA  4'h4
`define TCS_X_RDATA  4'h8
`define TCS_X_STAT   4'hC
`define TCS_CMD_WIDE 8
`define TCS_CMD_WR   9
`define TCS_ST_BUSY  0
`define TCS_ST_DONE  1
`define TCS_ST_ERR   2
`endif

// ===== hdl/tcs_pkg.sv
// Types shared by the timer core and its controller.
// Assumes tcs_regs.svh on the include path.
package tcs_pkg;
   typedef logic [15:0] tcs_word_t;
   // Counter clear source of one channel
   typedef enum logic [1:0] {TCS_CLR_NONE, TCS_CLR_A, TCS_CLR_B, TCS_CLR_SYNC} tcs_clr_t;
   // Controller sequencer
   typedef enum logic [1:0] {TCS_H_IDLE, TCS_H_REQ, TCS_H_WAIT} tcs_hst_t;
endpackage : tcs_pkg

// ===== hdl/tcs_bus_if.sv
// Word bus between controller and timer core.
// Assumes both ends run on the same aclk.
`timescale 1ns/100ps
`default_nettype none
interface tcs_bus_if;
   logic [4:0]  addr;  // Word address
   logic        req;   // One-cycle request
   logic        we;    // Write when high
   logic        wide;  // 16-bit access when high
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;   // One-cycle answer
   modport dev  (input addr, req, we, wide, wdata, output rdata, ack);
   modport host (output addr, req, we, wide, wdata, input rdata, ack);
endinterface : tcs_bus_if
`default_nettype wire

// ===== hdl/tcs_device.sv
// Timer counter core: three 16-bit up-counters, eight general registers,
// run/sync control, pin levels and overflow flags.
// Assumes requests from tcs_bus_if are synchronous to aclk.
// Behaviour
// - Three readable, writable 16-bit up-counters
// - Counters zero on reset and standby
// - General registers compare or capture
// - Eight general registers: four, two, two
// - General registers all-ones on reset, standby
// - Channel 0: C buffers A, D buffers B
// - Counters, general registers: 16-bit access only
// - Run bits 2..0 start channel counting
// - Stop counter before changing mode, clock
// - Stopping keeps the compare output level
// - Pin control write while stopped sets level
// - Sync bits 2..0 select synchronous operation
// - Unsynchronised channel presets, clears alone
// - Synchronised channels preset and clear together
// - Synchronous operation needs two sync bits
// - Sync clear needs sync bit, clear source
// - Rollover sets overflow flag; read-then-zero clears
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`include "tcs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tcs_device
   import tcs_pkg::*;
#(
   parameter int DIV = `TCS_DIV_DEF
) (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Hardware standby, high while in standby
   input  wire logic       standby,
   // Register bus
   tcs_bus_if.dev          bus,
   // Capture strobes, one-cycle pulses
   input  wire logic [2:0] cap_a,
   input  wire logic [2:0] cap_b,
   // Timer pins
   output logic [2:0]      pin_o,
   output logic [2:0]      pin_oe,
   // Overflow flags
   output logic [2:0]      overflow_flag
);
   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (DIV < 1 || DIV > 65535) begin : g_chk
      $error("tcs_device: DIV out of range");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   tcs_word_t cnt_ff [3];
   tcs_word_t gr_ff  [8];
   tcs_word_t nxt_cnt [3];
   tcs_word_t nxt_gr  [8];
   tcs_clr_t  clr_ff [3];
   logic [2:0] pio_ff [3];
   logic [2:0] run_ff, sync_ff, ovf_ff, seen_ff, pin_ff;
   logic [2:0] nxt_ovf, nxt_seen, nxt_pin;
   logic [1:0] buf_ff;
   logic [15:0] div_ff;
   logic        ack_ff;
   tcs_word_t   rdata_ff, rd_mux;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Standby restarts everything like reset
   wire rst_all  = ~aresetn | standby;
   wire wr       = bus.req & bus.we;
   wire rd       = bus.req & ~bus.we;
   wire is_word  = bus.addr <= `TCS_A_GRL;
   // Byte access to word registers is dropped
   wire wr_word  = wr & bus.wide & is_word;
   wire wr_run   = wr & (bus.addr == `TCS_A_RUN);
   wire wr_sync  = wr & (bus.addr == `TCS_A_SYNC);
   wire wr_stat  = wr & (bus.addr == `TCS_A_STAT);
   wire rd_stat  = rd & (bus.addr == `TCS_A_STAT);
   wire wr_buf   = wr & (bus.addr == `TCS_A_BUF);
   wire div_tick = div_ff == 16'(DIV - 1);

   logic [2:0] tick, m_a, m_b, c_a, c_b, self_clr, clr_now, wr_cnt, load;
   logic [2:0] wr_tcs, wr_pio, ovf_set;
   wire        sync_src = |(self_clr & sync_ff);
   wire        sync_pre = |(wr_cnt & sync_ff);

   for (genvar c = 0; c < 3; c++) begin : g_ch
      localparam int IA = (c == 0) ? 0 : 2 * c + 2;
      // Compare matches only in compare mode
      assign tick[c]     = div_tick & run_ff[c];
      assign m_a[c]      = ~pio_ff[c][`TCS_PIO_CAPA] & (cnt_ff[c] == gr_ff[IA]);
      assign m_b[c]      = ~pio_ff[c][`TCS_PIO_CAPB] & (cnt_ff[c] == gr_ff[IA+1]);
      assign c_a[c]      = cap_a[c] & pio_ff[c][`TCS_PIO_CAPA];
      assign c_b[c]      = cap_b[c] & pio_ff[c][`TCS_PIO_CAPB];
      assign self_clr[c] = (clr_ff[c] == TCS_CLR_A & (tick[c] & m_a[c] | c_a[c]))
                         | (clr_ff[c] == TCS_CLR_B & (tick[c] & m_b[c] | c_b[c]));
      // Sync clear follows any synchronised self-clearing channel
      assign clr_now[c]  = self_clr[c]
                         | (sync_ff[c] & clr_ff[c] == TCS_CLR_SYNC & sync_src);
      assign wr_cnt[c]   = wr_word & (bus.addr == `TCS_A_CNT + 5'(c));
      assign load[c]     = wr_cnt[c] | (sync_ff[c] & sync_pre);
      assign wr_tcs[c]   = wr & (bus.addr == `TCS_A_TCS + 5'(c));
      assign wr_pio[c]   = wr & (bus.addr == `TCS_A_PIO + 5'(c));
      assign ovf_set[c]  = tick[c] & ~load[c] & ~clr_now[c]
                         & (cnt_ff[c] == 16'hFFFF);
   end

   // ----------------------------------------
   // Counter and general register next state
   // ----------------------------------------
   // Priority: bus write, clear, increment
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         if (load[c]) begin
            nxt_cnt[c] = bus.wdata;
         end else if (clr_now[c]) begin
            nxt_cnt[c] = `TCS_CNT_RST;
         end else if (tick[c]) begin
            nxt_cnt[c] = cnt_ff[c] + 16'h0001;
         end else begin
            nxt_cnt[c] = cnt_ff[c];
         end
      end
      for (int g = 0; g < 8; g++) begin
         nxt_gr[g] = gr_ff[g];
      end
      // Capture, and buffer transfers on channel 0
      for (int c = 0; c < 3; c++) begin
         if (c_a[c]) begin
            nxt_gr[(c == 0) ? 0 : 2 * c + 2] = cnt_ff[c];
         end
         if (c_b[c]) begin
            nxt_gr[(c == 0) ? 1 : 2 * c + 3] = cnt_ff[c];
         end
      end
      if (buf_ff[0] & c_a[0]) begin
         nxt_gr[2] = gr_ff[0];
      end
      if (buf_ff[0] & tick[0] & m_a[0]) begin
         nxt_gr[0] = gr_ff[2];
      end
      if (buf_ff[1] & c_b[0]) begin
         nxt_gr[3] = gr_ff[1];
      end
      if (buf_ff[1] & tick[0] & m_b[0]) begin
         nxt_gr[1] = gr_ff[3];
      end
      // Software write wins over capture
      for (int g = 0; g < 8; g++) begin
         if (wr_word & (bus.addr == `TCS_A_GR + 5'(g))) begin
            nxt_gr[g] = bus.wdata;
         end
      end
   end

   // ----------------------------------------
   // Flags and pin levels
   // ----------------------------------------
   // Set wins over a clear in the same cycle
   always_comb begin
      nxt_seen = seen_ff | (rd_stat ? ovf_ff : 3'h0);
      nxt_ovf  = ovf_ff;
      if (wr_stat) begin
         nxt_ovf  = ovf_ff & ~(seen_ff & ~bus.wdata[2:0]);
         nxt_seen = nxt_seen & bus.wdata[2:0];
      end
      nxt_ovf = nxt_ovf | ovf_set;
      for (int c = 0; c < 3; c++) begin
         if (wr_pio[c] & ~run_ff[c]) begin
            nxt_pin[c] = bus.wdata[`TCS_PIO_INIT];
         end else if (tick[c] & m_a[c]) begin
            nxt_pin[c] = ~pin_ff[c];
         end else begin
            nxt_pin[c] = pin_ff[c];
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb begin
      rd_mux = 16'h0000;
      if (is_word) begin
         if (bus.wide) begin
            rd_mux = (bus.addr < `TCS_A_GR) ? cnt_ff[bus.addr[1:0]]
                                            : gr_ff[3'(bus.addr - `TCS_A_GR)];
         end
      end else if (bus.addr == `TCS_A_RUN) begin
         rd_mux = {13'h0000, run_ff};
      end else if (bus.addr == `TCS_A_SYNC) begin
         rd_mux = {13'h0000, sync_ff};
      end else if (bus.addr >= `TCS_A_TCS && bus.addr < `TCS_A_PIO) begin
         rd_mux = {14'h0000, clr_ff[2'(bus.addr - `TCS_A_TCS)]};
      end else if (bus.addr >= `TCS_A_PIO && bus.addr < `TCS_A_STAT) begin
         rd_mux = {13'h0000, pio_ff[2'(bus.addr - `TCS_A_PIO)]};
      end else if (bus.addr == `TCS_A_STAT) begin
         rd_mux = {13'h0000, ovf_ff};
      end else if (bus.addr == `TCS_A_BUF) begin
         rd_mux = {14'h0000, buf_ff};
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (rst_all) begin
         for (int c = 0; c < 3; c++) begin
            cnt_ff[c] <= `TCS_CNT_RST;
            clr_ff[c] <= TCS_CLR_NONE;
            pio_ff[c] <= 3'h0;
         end
         for (int g = 0; g < 8; g++) begin
            gr_ff[g] <= `TCS_GR_RST;
         end
         run_ff   <= 3'h0;
         sync_ff  <= 3'h0;
         ovf_ff   <= 3'h0;
         seen_ff  <= 3'h0;
         pin_ff   <= 3'h0;
         buf_ff   <= 2'h0;
         div_ff   <= 16'h0000;
         ack_ff   <= 1'b0;
         rdata_ff <= 16'h0000;
      end else begin
         cnt_ff   <= nxt_cnt;
         gr_ff    <= nxt_gr;
         ovf_ff   <= nxt_ovf;
         seen_ff  <= nxt_seen;
         pin_ff   <= nxt_pin;
         div_ff   <= div_tick ? 16'h0000 : div_ff + 16'h0001;
         ack_ff   <= bus.req;
         rdata_ff <= rd ? rd_mux : rdata_ff;
         if (wr_run) begin
            run_ff <= bus.wdata[2:0];
         end
         if (wr_sync) begin
            sync_ff <= bus.wdata[2:0];
         end
         if (wr_buf) begin
            buf_ff <= bus.wdata[1:0];
         end
         for (int c = 0; c < 3; c++) begin
            if (wr_tcs[c]) begin
               clr_ff[c] <= tcs_clr_t'(bus.wdata[1:0]);
            end
            if (wr_pio[c]) begin
               pio_ff[c] <= bus.wdata[2:0];
            end
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Pin drives only while channel A compares
   assign pin_o         = pin_ff;
   assign overflow_flag = ovf_ff;
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         pin_oe[c] = ~pio_ff[c][`TCS_PIO_CAPA];
      end
   end
   assign bus.ack   = ack_ff;
   assign bus.rdata = rdata_ff;
endmodule : tcs_device
`default_nettype wire

// ===== hdl/tcs_host.sv
// Controller: takes orders over AXI4-Lite and runs them on the word bus.
// Assumes the timer core answers each request with a one-cycle ack.
`include "tcs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tcs_host
   import tcs_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Timer bus
   tcs_bus_if.host          bus
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   tcs_hst_t   st_ff;
   logic       aw_ff, w_ff, bv_ff, rv_ff, done_ff, err_ff;
   logic [3:0] awa_ff;
   logic [31:0] wd_ff, rd_ff;
   logic [9:0] cmd_ff;
   logic [15:0] wdat_ff, bdat_ff;
   logic [2:0] run_sh_ff, sync_sh_ff;

   // ----------------------------------------
   // Decode and order checks
   // ----------------------------------------
   wire        do_wr  = aw_ff & w_ff & ~bv_ff;
   wire        wr_cmd = do_wr & (awa_ff == `TCS_X_CMD);
   wire [4:0]  a      = wd_ff[4:0];
   wire        c_wr   = wd_ff[`TCS_CMD_WR];
   wire        is_tcs = a >= `TCS_A_TCS && a < `TCS_A_PIO;
   wire [1:0]  ch     = 2'(a - `TCS_A_TCS);
   wire        bad_w  = ~wd_ff[`TCS_CMD_WIDE] & a <= `TCS_A_GRL;
   wire        bad_r  = c_wr & is_tcs & run_sh_ff[ch];
   wire        bad_s  = c_wr & a == `TCS_A_SYNC
                      & $countones(wdat_ff[2:0]) == 1;
   wire        bad_c  = c_wr & is_tcs & wdat_ff[1:0] == TCS_CLR_SYNC
                      & ~sync_sh_ff[ch];
   wire        refuse = bad_w | bad_r | bad_s | bad_c;
   wire        start  = wr_cmd & st_ff == TCS_H_IDLE & ~refuse;
   wire        narrow = a == `TCS_A_RUN | a == `TCS_A_SYNC;
   wire        bad_a  = |awa_ff[1:0];

   // ----------------------------------------
   // Handshakes
   // ----------------------------------------
   assign s_axi_awready = ~aw_ff & ~bv_ff;
   assign s_axi_wready  = ~w_ff & ~bv_ff;
   assign s_axi_bvalid  = bv_ff;
   assign s_axi_arready = ~rv_ff;
   assign s_axi_rvalid  = rv_ff;
   assign s_axi_rresp   = 2'h0;
   assign s_axi_rdata   = rd_ff;
   assign bus.req       = st_ff == TCS_H_REQ;
   assign bus.addr      = cmd_ff[4:0];
   assign bus.we        = cmd_ff[`TCS_CMD_WR];
   assign bus.wide      = cmd_ff[`TCS_CMD_WIDE];
   assign bus.wdata     = bdat_ff;

   // ----------------------------------------
   // AXI side and sequencer
   // ----------------------------------------
   // Done and error set win over their clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= TCS_H_IDLE;
         {aw_ff, w_ff, bv_ff, rv_ff, done_ff, err_ff} <= 6'h00;
         awa_ff <= 4'h0;
         wd_ff  <= 32'h0000_0000;
         rd_ff  <= 32'h0000_0000;
         cmd_ff <= 10'h000;
         wdat_ff <= 16'h0000;
         bdat_ff <= 16'h0000;
         run_sh_ff  <= 3'h0;
         sync_sh_ff <= 3'h0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_ff  <= 1'b1;
            awa_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_ff  <= 1'b1;
            wd_ff <= s_axi_wdata;
         end
         if (do_wr) begin
            {aw_ff, w_ff, bv_ff} <= 3'b001;
            s_axi_bresp <= bad_a ? 2'h2 : 2'h0;
            if (awa_ff == `TCS_X_WDATA) begin
               wdat_ff <= wd_ff[15:0];
            end
            if (awa_ff == `TCS_X_STAT) begin
               done_ff <= done_ff & ~wd_ff[`TCS_ST_DONE];
               err_ff  <= err_ff & ~wd_ff[`TCS_ST_ERR];
            end
         end else if (bv_ff & s_axi_bready) begin
            bv_ff <= 1'b0;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            rv_ff <= 1'b1;
            unique case (s_axi_araddr)
               `TCS_X_CMD:   rd_ff <= {22'h000000, cmd_ff};
               `TCS_X_WDATA: rd_ff <= {16'h0000, wdat_ff};
               `TCS_X_RDATA: rd_ff <= {16'h0000, bdat_ff};
               `TCS_X_STAT:  rd_ff <= {29'h00000000, err_ff, done_ff,
                                       st_ff != TCS_H_IDLE};
               default:      rd_ff <= 32'h0000_0000;
            endcase
         end else if (rv_ff & s_axi_rready) begin
            rv_ff <= 1'b0;
         end
         if (wr_cmd & ~start) begin
            err_ff <= 1'b1;
         end
         unique case (st_ff)
            TCS_H_IDLE: begin
               if (start) begin
                  st_ff   <= TCS_H_REQ;
                  cmd_ff  <= wd_ff[9:0];
                  bdat_ff <= narrow ? wdat_ff & `TCS_CH_MASK : wdat_ff;
                  if (c_wr & a == `TCS_A_RUN) begin
                     run_sh_ff <= wdat_ff[2:0];
                  end
                  if (c_wr & a == `TCS_A_SYNC) begin
                     sync_sh_ff <= wdat_ff[2:0];
                  end
               end
            end
            TCS_H_REQ:  st_ff <= TCS_H_WAIT;
            TCS_H_WAIT: begin
               if (bus.ack) begin
                  st_ff   <= TCS_H_IDLE;
                  done_ff <= 1'b1;
                  if (!cmd_ff[`TCS_CMD_WR]) begin
                     bdat_ff <= bus.rdata;
                  end
               end
            end
         endcase
      end
   end
endmodule : tcs_host
`default_nettype wire

// ===== tb/tcs_bus_properties.sv
// ----------------------------------------
// Word bus checker
// ----------------------------------------
// Concurrent checks on the controller to timer core bus.
// Assumes one aclk domain and instantiation beside tcs_bus_if.
`include "tcs_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tcs_bus_properties (
   // Clock, reset, standby
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        standby,
   // Bus signals
   input wire logic [4:0]  addr,
   input wire logic        req,
   input wire logic        we,
   input wire logic        wide,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        ack
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Answer timing, exactly one cycle late and one cycle long
   chk_ack_after_req: assert property (req |=> ack) else $error("ack missing after req");
   chk_ack_single: assert property (ack |=> !ack) else $error("ack longer than one cycle");
   chk_ack_cause: assert property (!req |=> !ack) else $error("ack without req");
   // Host leaves two idle cycles after each request
   chk_host_spacing: assert property (req |=> !req [*2]) else $error("req too close");
   // Word registers never see narrow requests
   chk_wide_only: assert property (req && addr <= `TCS_A_GRL |-> wide)
      else $error("narrow access to word register");
   // Reserved run and sync bits read zero and are written as zero
   chk_run_reserved: assert property (req && !we && addr == `TCS_A_RUN
      |=> rdata[15:3] == 13'h0000) else $error("run reserved bits set");
   chk_sync_reserved: assert property (req && !we && addr == `TCS_A_SYNC
      |=> rdata[15:3] == 13'h0000) else $error("sync reserved bits set");
   chk_resv_write: assert property (req && we && addr inside {`TCS_A_RUN, `TCS_A_SYNC}
      |-> wdata[15:3] == 13'h0000) else $error("reserved bits written");
   // Read data stands until the next read; standby may clear it
   chk_rdata_hold: assert property (!(req && !we) && !standby |=> $stable(rdata))
      else $error("rdata changed without read");

   cover property (req && we);
   cover property (req && !we && wide);
   cover property (ack ##1 !ack [*2] ##1 req);
endmodule : tcs_bus_properties
`default_nettype wire

// ===== tb/testbench.sv
// ----------------------------------------
// Timer core with controller, driven over AXI4-Lite
// ----------------------------------------
// Self-checking bench: table of ordinary accesses, then hand tests.
// Assumes hdl/ files compiled first and tcs_regs.svh on the path.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
   $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module testbench
   import tcs_pkg::*;
;
   typedef struct packed {logic wr; logic [4:0] a; logic [15:0] d; logic [15:0] e;} tcs_row_t;
   logic aclk = 0, aresetn = 0, standby = 0;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] cap_a = '0, cap_b = '0, pin_o, pin_oe, overflow_flag, st;
   logic [15:0] q, q1;
   int fail_count = 0, check_count = 0;
   // Reset values, then write-readback pairs
   tcs_row_t rows [12] = '{
      '{0, 5'h00, 16'h0, 16'h0000}, '{0, 5'h02, 16'h0, 16'h0000},
      '{0, 5'h03, 16'h0, 16'hFFFF}, '{0, 5'h0A, 16'h0, 16'hFFFF},
      '{0, 5'h0B, 16'h0, 16'h0000}, '{0, 5'h0C, 16'h0, 16'h0000},
      '{1, 5'h06, 16'h1234, 16'h0}, '{0, 5'h06, 16'h0, 16'h1234},
      '{1, 5'h01, 16'hABCD, 16'h0}, '{0, 5'h01, 16'h0, 16'hABCD},
      '{1, 5'h0B, 16'h00F8, 16'h0}, '{0, 5'h0B, 16'h0, 16'h0000}};

   tcs_bus_if tcs_bus_if_inst ();
   tcs_device #(.DIV(1)) tcs_device_inst (.aclk(aclk), .aresetn(aresetn), .standby(standby),
      .bus(tcs_bus_if_inst.dev), .cap_a(cap_a), .cap_b(cap_b), .pin_o(pin_o),
      .pin_oe(pin_oe), .overflow_flag(overflow_flag));
   tcs_host tcs_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bus(tcs_bus_if_inst.host));
   tcs_bus_properties tcs_bus_properties_inst (.aclk(aclk), .aresetn(aresetn),
      .standby(standby), .addr(tcs_bus_if_inst.addr), .req(tcs_bus_if_inst.req),
      .we(tcs_bus_if_inst.we), .wide(tcs_bus_if_inst.wide), .wdata(tcs_bus_if_inst.wdata),
      .rdata(tcs_bus_if_inst.rdata), .ack(tcs_bus_if_inst.ack));

   // 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end

   // AXI write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic pa, pw;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      s_axi_bready <= 1; pa = 1; pw = 1;
      while (pa || pw) begin
         @(posedge aclk);
         if (pa && s_axi_awready) begin s_axi_awvalid <= 0; pa = 0; end
         if (pw && s_axi_wready) begin s_axi_wvalid <= 0; pw = 0; end
      end
      while (!s_axi_bvalid) @(posedge aclk);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : axi_wr

   // AXI read, ready held until the data is seen
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata;
      `CHK("rresp", 2'b00, s_axi_rresp)
      s_axi_rready <= 0;
   endtask : axi_rd

   // One timer bus transfer through the controller; polls status, clears it after
   task automatic op(input logic wr, input logic [4:0] a, input logic wd, input logic [15:0] d,
                     output logic [15:0] rq, output logic [2:0] rst);
      logic [31:0] v;
      logic [1:0]  rs;
      axi_wr(4'h4, {16'h0000, d}, rs);
      axi_wr(4'h0, {22'h0, wr, wd, 3'h0, a}, rs);
      rst = 3'h0;
      for (int i = 0; i < 40 && !(rst[1] || rst[2]); i++) begin
         axi_rd(4'hC, v);
         rst = v[2:0];
      end
      if (!(rst[1] || rst[2])) fail_count++;
      rq = 16'h0000;
      if (!wr) begin axi_rd(4'h8, v); rq = v[15:0]; end
      axi_wr(4'hC, 32'h0000_0006, rs);
   endtask : op

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // Watchdog, far above the test length
   initial begin
      repeat (30000) @(posedge aclk);
      fail_count++;
      end_sim();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      foreach (rows[i]) begin
         op(rows[i].wr, rows[i].a, 1'b1, rows[i].d, q, st);
         if (!rows[i].wr) `CHK("table read", rows[i].e, q)
      end
      $display("test table done");
      // Run, then stop: counter moved and then holds
      op(1, 5'h00, 1, 16'h0000, q, st);
      op(1, 5'h0B, 1, 16'h0001, q, st);
      op(1, 5'h0B, 1, 16'h0000, q, st);
      op(0, 5'h00, 1, 16'h0, q1, st);
      op(0, 5'h00, 1, 16'h0, q, st);
      `CHK("counted", 1'b1, q1 != 16'h0000)
      `CHK("stopped", q1, q)
      $display("test run done");
      // Rollover sets the flag; read then write zero clears it
      op(1, 5'h02, 1, 16'hFFFE, q, st);
      op(1, 5'h0B, 1, 16'h0004, q, st);
      op(1, 5'h0B, 1, 16'h0000, q, st);
      `CHK("overflow pin", 1'b1, overflow_flag[2])
      op(0, 5'h13, 1, 16'h0, q, st);
      `CHK("overflow read", 1'b1, q[2])
      op(1, 5'h13, 1, 16'h0000, q, st);
      `CHK("overflow clear", 1'b0, overflow_flag[2])
      $display("test overflow done");
      // Presetting ch0 carries to ch1 only
      op(1, 5'h0C, 1, 16'h0003, q, st);
      op(1, 5'h02, 1, 16'h0042, q, st);
      op(1, 5'h00, 1, 16'h5555, q, st);
      op(0, 5'h01, 1, 16'h0, q, st);
      `CHK("sync preset", 16'h5555, q)
      op(0, 5'h02, 1, 16'h0, q, st);
      `CHK("independent", 16'h0042, q)
      op(1, 5'h0C, 1, 16'h0000, q, st);
      $display("test sync done");
      // Refusals
      op(1, 5'h0C, 1, 16'h0001, q, st);
      `CHK("single sync", 1'b1, st[2])
      op(0, 5'h03, 0, 16'h0, q, st);
      `CHK("narrow word", 1'b1, st[2])
      axi_wr(4'h1, 32'h0, r);
      `CHK("misaligned", 2'b10, r)
      op(1, 5'h0D, 1, 16'h0003, q, st);
      `CHK("sync clear", 1'b1, st[2])
      op(1, 5'h0B, 1, 16'h0004, q, st);
      op(1, 5'h0F, 1, 16'h0000, q, st);
      `CHK("mode running", 1'b1, st[2])
      $display("test refuse done");
      // Pin initial level while stopped
      op(1, 5'h11, 1, 16'h0004, q, st);
      `CHK("pin init", 1'b1, pin_o[1])
      // Capture into A, old A moves to buffer C
      op(1, 5'h03, 1, 16'h1111, q, st);
      op(1, 5'h00, 1, 16'h2222, q, st);
      op(1, 5'h10, 1, 16'h0001, q, st);
      `CHK("pin drive", 1'b0, pin_oe[0])
      op(1, 5'h11, 1, 16'h0006, q, st);
      op(1, 5'h14, 1, 16'h0001, q, st);
      @(posedge aclk) cap_a <= 3'b001;
      cap_b <= 3'b010;
      @(posedge aclk) cap_a <= 3'b000;
      cap_b <= 3'b000;
      op(0, 5'h03, 1, 16'h0, q, st);
      `CHK("capture", 16'h2222, q)
      op(0, 5'h05, 1, 16'h0, q, st);
      `CHK("buffer", 16'h1111, q)
      op(0, 5'h08, 1, 16'h0, q, st);
      `CHK("capture b", 16'h5555, q)
      $display("test capture done");
      // Hardware standby acts as reset
      @(posedge aclk) standby <= 1;
      repeat (2) @(posedge aclk);
      standby <= 0;
      op(0, 5'h00, 1, 16'h0, q, st);
      `CHK("standby count", 16'h0000, q)
      op(0, 5'h03, 1, 16'h0, q, st);
      `CHK("standby general", 16'hFFFF, q)
      $display("test standby done");
      end_sim();
   end
endmodule : testbench
`default_nettype wire
